// ### dv/swmon_asserts.sv
`timescale 1ns/10ps
// watches the serial link where both ends are design modules
module swmon_asserts (
  input  wire logic       ref_clk_i, // 50 MHz
  input  wire logic       rstn_i,    // async active low
  input  wire logic       cs_n,      // chip select
  input  wire logic       sclk,      // serial clock
  input  wire logic       sdo,       // device data out
  input  wire logic       sdo_oe,    // device drives sdo
  input  wire logic       int_n_oe,  // device pulls interrupt
  input  wire logic       wake_n_oe  // device pulls wake
);
  logic [3:0] hi_cnt; // cycles with cs_n high, saturating
  logic [5:0] n_rise; // rising sclk edges in this frame

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // idle time since deselect; saturates so long idles never wrap back into the window
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hi_cnt <= 4'hF;
    end else if (!cs_n) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hF) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end

  // frame length in clocks
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_rise <= 6'h0;
    end else if ($fell(cs_n)) begin
      n_rise <= 6'h0;
    end else if ($rose(sclk) && !cs_n) begin
      n_rise <= n_rise + 6'h1;
    end
  end

  AST_SDO_REL: assert property ($rose(cs_n) |-> ##[1:6] !sdo_oe)
    else $error("data out still driven after deselect");
  AST_SDO_OFF: assert property (hi_cnt > 4'h6 |-> !sdo_oe)
    else $error("data out driven while deselected");
  AST_SDO_EN: assert property ($rose(sdo_oe) |-> !cs_n)
    else $error("data out enabled without select");
  AST_CS_EDGE: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("select moved with serial clock high");
  AST_SCLK_IDLE: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock not idle low");
  AST_SDO_HOLD: assert property ($fell(sclk) && sdo_oe |=> $stable(sdo) [*2])
    else $error("data out moved at falling clock");
  AST_BITS: assert property ($rose(cs_n) |-> n_rise == 6'h18 || n_rise == 6'h30)
    else $error("frame length not 24 or 48 clocks");
  AST_INT_CLR: assert property ($fell(int_n_oe) |-> hi_cnt <= 4'h8)
    else $error("interrupt released away from deselect");

  cover property ($rose(cs_n) && n_rise == 6'h30);
  cover property ($rose(int_n_oe));
  cover property ($rose(wake_n_oe));
endmodule : swmon_asserts

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        ref_clk_i, rstn_i, wr_i, rd_i, logic_pwr_i, thermal_i, sleep_req_i, int_timer_i, sleep_o;
  logic        rflag;
  logic [3:0]  addr_i;
  logic [4:0]  analog_sel_o;
  logic [7:0]  dp_above_i, dp_polarity_o, pol;
  logic [13:0] go_above_i;
  logic [21:0] wake_en_o, metal_o, wet_tmr_en_o, tri_o;
  logic [23:0] wdata_i, rdata_o, rx, st;
  int          n_fail, comparisons;
  typedef struct packed {logic [23:0] cmd; logic [7:0] dp; logic [13:0] go; logic [23:0] exp;} row_s;
  row_s        rows [12];

  swmon_if lnk ();
  swmon_host swmon_host_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lnk(lnk.host));
  swmon_dev swmon_dev_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .dp_above_i(dp_above_i),
    .go_above_i(go_above_i), .logic_pwr_i(logic_pwr_i), .thermal_i(thermal_i), .sleep_req_i(sleep_req_i),
    .int_timer_i(int_timer_i), .dp_polarity_o(dp_polarity_o), .wake_en_o(wake_en_o), .metal_o(metal_o),
    .wet_tmr_en_o(wet_tmr_en_o), .tri_o(tri_o), .analog_sel_o(analog_sel_o), .sleep_o(sleep_o), .lnk(lnk.dev));
  swmon_asserts swmon_asserts_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .int_n_oe(lnk.int_n_oe), .wake_n_oe(lnk.wake_n_oe));

  // clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // bus tasks are entered just after a rising edge and leave just after one
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
    tick(1);
  endtask : rd

  // one frame; busy polling is bounded so a stuck host shows up as a mismatch
  task automatic xfer(input logic [23:0] c, input logic [1:0] ctl, output logic [23:0] r);
    int i;
    wr(swmon_pkg::HA_TXLO, c);
    wr(swmon_pkg::HA_CTRL, {22'h0, ctl});
    for (i = 0; i < 400; i++) begin
      rd(swmon_pkg::HA_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    chk("busy", 24'h0, {23'h0, st[0]});
    rd(swmon_pkg::HA_RXLO, r);
  endtask : xfer

  // sleep is entered from a short request while deselected
  task automatic nap();
    sleep_req_i <= 1'b1;
    tick(8);
    sleep_req_i <= 1'b0;
    tick(8);
    chk("asleep", 24'h1, {23'h0, sleep_o});
    chk("wake line", 24'h1, {23'h0, lnk.wake_n});
  endtask : nap

  function automatic logic [23:0] stat(input logic [7:0] dp, input logic [13:0] go, input logic th);
    return {th, rflag, ~go, ~(dp ^ pol)};
  endfunction : stat

  function automatic logic [23:0] cfg(input logic [7:0] op);
    case (op)
      swmon_pkg::OP_SETTINGS: return {16'h0, dp_polarity_o};
      swmon_pkg::OP_WAKE_DP:  return {16'h0, wake_en_o[7:0]};
      swmon_pkg::OP_WAKE_GO:  return {10'h0, wake_en_o[21:8]};
      swmon_pkg::OP_METAL_DP: return {16'h0, metal_o[7:0]};
      swmon_pkg::OP_METAL_GO: return {10'h0, metal_o[21:8]};
      swmon_pkg::OP_WTMR_DP:  return {16'h0, wet_tmr_en_o[7:0]};
      swmon_pkg::OP_WTMR_GO:  return {10'h0, wet_tmr_en_o[21:8]};
      swmon_pkg::OP_TRI_DP:   return {16'h0, tri_o[7:0]};
      swmon_pkg::OP_TRI_GO:   return {10'h0, tri_o[21:8]};
      swmon_pkg::OP_ANALOG:   return {19'h0, analog_sel_o};
      default:                return {2'h0, wake_en_o};
    endcase
  endfunction : cfg

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // watchdog: the whole sequence needs about a fifth of this
  initial begin
    #400000;
    n_fail++;
    close_out();
  end

  initial begin
    {rstn_i, wr_i, rd_i, thermal_i, sleep_req_i, int_timer_i} = '0;
    {addr_i, wdata_i, dp_above_i, go_above_i} = '0;
    logic_pwr_i = 1'b1;
    lnk.wake_ext_oe = 1'b0;
    lnk.int_ext_oe = 1'b0;
    pol = 8'hFF;
    rflag = 1'b1;
    rows = '{'{24'h0100F0, 8'hA5, 14'h1234, 24'h0000F0}, '{24'h020055, 8'h5A, 14'h0ABC, 24'h000055},
      '{24'h032AAA, 8'h00, 14'h3FFF, 24'h002AAA}, '{24'h0400C3, 8'hFF, 14'h0000, 24'h0000C3},
      '{24'h051555, 8'h3C, 14'h2001, 24'h001555}, '{24'h07003C, 8'hC3, 14'h1FFE, 24'h00003C},
      '{24'h083F00, 8'h81, 14'h0F0F, 24'h003F00}, '{24'h090081, 8'h7E, 14'h30C3, 24'h000081},
      '{24'h0A2001, 8'h18, 14'h2222, 24'h002001}, '{24'h0B0013, 8'hE7, 14'h1111, 24'h000013},
      '{24'h7F0000, 8'h99, 14'h0555, 24'h3FFFFF}, '{24'h01000F, 8'h66, 14'h3AAA, 24'h00000F}};
    tick(2);
    rstn_i <= 1'b1;
    tick(1);
    chk("polarity", 24'h0000FF, {16'h0, dp_polarity_o});
    chk("wake en", 24'h3FFFFF, {2'h0, wake_en_o & metal_o & wet_tmr_en_o & tri_o});
    chk("analog", 24'h0, {19'h0, analog_sel_o});
    chk("wake line", 24'h0, {23'h0, lnk.wake_n});
    chk("data out off", 24'h0, {23'h0, lnk.sdo_oe});
    // every command code, with switch patterns that exercise both polarities
    foreach (rows[i]) begin
      dp_above_i <= rows[i].dp;
      go_above_i <= rows[i].go;
      thermal_i <= i[0];
      tick(8);
      xfer(rows[i].cmd, 2'h1, rx);
      chk("status", stat(rows[i].dp, rows[i].go, i[0]), rx);
      tick(8);
      chk("config", rows[i].exp, cfg(rows[i].cmd[23:16]));
      rflag = (rows[i].cmd[23:16] == swmon_pkg::OP_RESET);
      if (rflag) pol = 8'hFF;
      else if (rows[i].cmd[23:16] == swmon_pkg::OP_SETTINGS) pol = rows[i].cmd[7:0];
    end
    // chained pair: second word is the command, first word comes back behind the status
    wr(swmon_pkg::HA_TXHI, 24'h0B0009);
    xfer(24'h0B0005, 2'h3, rx);
    chk("chain tail", 24'h0B0009, rx);
    rd(swmon_pkg::HA_RXHI, rx);
    chk("chain status", stat(rows[11].dp, rows[11].go, 1'b1), rx);
    tick(8);
    chk("chain cmd", 24'h000005, cfg(swmon_pkg::OP_ANALOG));
    rd(4'hF, rx);
    chk("unmapped", 24'h0, rx);
    // interrupt held over a frame in which a switch moves, cleared by the next
    go_above_i <= rows[11].go ^ 14'h0001;
    tick(8);
    chk("int set", 24'h0, {23'h0, lnk.int_n});
    fork
      xfer(24'h0B0000, 2'h1, rx);
      begin
        tick(60);
        go_above_i <= rows[11].go;
      end
    join
    tick(8);
    chk("int held", 24'h0, {23'h0, lnk.int_n});
    xfer(24'h0B0000, 2'h1, rx);
    tick(8);
    chk("int clear", 24'h1, {23'h0, lnk.int_n});
    // wake sources
    nap();
    xfer(24'h0B0000, 2'h1, rx);
    rd(swmon_pkg::HA_STATUS, st);
    chk("wake access", 24'h1, {23'h0, st[3]});
    chk("cs wake", 24'h0, {23'h0, sleep_o});
    nap();
    lnk.wake_ext_oe <= 1'b1;
    tick(8);
    lnk.wake_ext_oe <= 1'b0;
    tick(8);
    chk("pin wake", 24'h0, {23'h0, sleep_o});
    // another device on the shared interrupt line wakes this one
    nap();
    lnk.int_ext_oe <= 1'b1;
    tick(8);
    lnk.int_ext_oe <= 1'b0;
    tick(8);
    chk("int wake", 24'h0, {23'h0, sleep_o});
    nap();
    logic_pwr_i <= 1'b0;
    tick(8);
    xfer(24'h0B0007, 2'h1, rx);
    chk("no serial", 24'hFFFFFF, rx);
    chk("kept asleep", 24'h1, {23'h0, sleep_o});
    int_timer_i <= 1'b1;
    tick(8);
    int_timer_i <= 1'b0;
    tick(8);
    chk("timer wake", 24'h0, {23'h0, sleep_o});
    logic_pwr_i <= 1'b1;
    tick(8);
    close_out();
  end
endmodule : testbench

// ### rtl/swmon_dev.sv
`timescale 1ns/10ps
module swmon_dev (
  input  wire logic        ref_clk_i,     // 50 MHz
  input  wire logic        rstn_i,        // async active low, battery power-on
  input  wire logic [7:0]  dp_above_i,    // dual_polarity_inputs above threshold
  input  wire logic [13:0] go_above_i,    // ground_only_inputs above threshold
  input  wire logic        logic_pwr_i,   // logic supply present
  input  wire logic        thermal_i,     // over-temperature flag
  input  wire logic        sleep_req_i,   // request to enter sleep
  input  wire logic        int_timer_i,   // sleep interrupt timer expired
  output logic [7:0]       dp_polarity_o, // 1 = battery polarity
  output logic [21:0]      wake_en_o,     // per input wake / interrupt enable
  output logic [21:0]      metal_o,       // high wetting current
  output logic [21:0]      wet_tmr_en_o,  // wetting timers enabled
  output logic [21:0]      tri_o,         // inputs high impedance
  output logic [4:0]       analog_sel_o,  // analog_select_output channel
  output logic             sleep_o,       // device in sleep mode
  swmon_if.dev             lnk            // serial link
);
  logic [1:0]  cs_s, sck_s, sdi_s, int_s, wk_s, pw_s;
  logic [1:0]  th_s;
  logic [7:0]  dp_s0, dp_s1;
  logic [13:0] go_s0, go_s1;
  logic        cs_d, sck_d, int_d, wk_d;
  logic        cs_fall, cs_rise, sck_rise, sck_fall, int_fall, wk_fall;
  logic        sel;
  logic [21:0] sw_now, sw_prev, change;
  logic        sw_evt;
  logic [23:0] shin, shout;
  logic        rst_flag, int_act, evt_in_cs;
  logic        sleep;
  logic        dev_rst;

  // every pin but sleep_req_i and int_timer_i crosses two flops before use
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_s <= 2'h3; sck_s <= 2'h0; sdi_s <= 2'h0; int_s <= 2'h3; wk_s <= 2'h3; pw_s <= 2'h0;
      dp_s0 <= 8'h00; dp_s1 <= 8'h00; go_s0 <= 14'h3FFF; go_s1 <= 14'h3FFF;
      cs_d <= 1'b1; sck_d <= 1'b0; int_d <= 1'b1; wk_d <= 1'b1;
      th_s <= 2'h0;
    end else begin
      th_s  <= {th_s[0], thermal_i};
      cs_s  <= {cs_s[0], lnk.cs_n};
      sck_s <= {sck_s[0], lnk.sclk};
      sdi_s <= {sdi_s[0], lnk.sdi};
      int_s <= {int_s[0], lnk.int_n};
      wk_s  <= {wk_s[0], lnk.wake_n};
      pw_s  <= {pw_s[0], logic_pwr_i};
      dp_s0 <= dp_above_i; dp_s1 <= dp_s0;
      go_s0 <= go_above_i; go_s1 <= go_s0;
      cs_d <= cs_s[1]; sck_d <= sck_s[1]; int_d <= int_s[1]; wk_d <= wk_s[1];
    end
  end

  // serial is dead without the logic supply
  assign cs_fall  = pw_s[1] & cs_d & ~cs_s[1];
  assign cs_rise  = pw_s[1] & ~cs_d & cs_s[1];
  assign sel      = pw_s[1] & ~cs_s[1];
  assign sck_rise = sel & ~sck_d & sck_s[1];
  assign sck_fall = sel & sck_d & ~sck_s[1];
  assign int_fall = int_d & ~int_s[1];
  assign wk_fall  = wk_d & ~wk_s[1];

  // threshold interpretation to closed = 1
  assign sw_now = {~go_s1,
                   ~(dp_s1 ^ dp_polarity_o)};
  assign change = (sw_now ^ sw_prev) & wake_en_o;
  assign sw_evt = |change;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) sw_prev <= 22'h000000;
    else sw_prev <= sw_now;
  end

  // input shift: falling sclk, msb first
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) shin <= 24'h000000;
    else if (sck_fall) shin <= {shin[22:0], sdi_s[1]};
  end

  // output shift: load at cs fall, next bit on rising sclk
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shout      <= 24'h000000;
      lnk.sdo    <= 1'b0;
      lnk.sdo_oe <= 1'b0;
    end else if (cs_fall) begin
      shout      <= {th_s[1], rst_flag, sw_now};
      lnk.sdo_oe <= 1'b1;
    end else if (cs_rise || !sel) begin
      lnk.sdo_oe <= 1'b0;
    end else if (sck_rise) begin
      lnk.sdo <= shout[23];
    end else if (sck_fall) begin
      // sdi follows the status out, so bit 25 onward repeats this frame's input
      shout   <= {shout[22:0], sdi_s[1]};
    end
  end

  assign dev_rst = cs_rise && shin[23:16] == swmon_pkg::OP_RESET;

  // command decode at cs rise defaults
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_polarity_o <= 8'hFF; wake_en_o <= 22'h3FFFFF; metal_o <= 22'h3FFFFF;
      wet_tmr_en_o <= 22'h3FFFFF; tri_o <= 22'h3FFFFF;
      analog_sel_o <= swmon_pkg::ANALOG_SEL_RST;
    end else if (dev_rst) begin
      dp_polarity_o <= 8'hFF; wake_en_o <= 22'h3FFFFF; metal_o <= 22'h3FFFFF;
      wet_tmr_en_o <= 22'h3FFFFF; tri_o <= 22'h3FFFFF;
      analog_sel_o <= swmon_pkg::ANALOG_SEL_RST;
    end else if (cs_rise && !sleep) begin
      case (shin[swmon_pkg::CMD_OP_MSB:swmon_pkg::CMD_OP_LSB])
        swmon_pkg::OP_SETTINGS: dp_polarity_o     <= shin[7:0];
        swmon_pkg::OP_WAKE_DP:  wake_en_o[7:0]    <= shin[7:0];
        swmon_pkg::OP_WAKE_GO:  wake_en_o[21:8]   <= shin[13:0];
        swmon_pkg::OP_METAL_DP: metal_o[7:0]      <= shin[7:0];
        swmon_pkg::OP_METAL_GO: metal_o[21:8]     <= shin[13:0];
        swmon_pkg::OP_WTMR_DP:  wet_tmr_en_o[7:0] <= shin[7:0];
        swmon_pkg::OP_WTMR_GO:  wet_tmr_en_o[21:8]<= shin[13:0];
        swmon_pkg::OP_TRI_DP:   tri_o[7:0]        <= shin[7:0];
        swmon_pkg::OP_TRI_GO:   tri_o[21:8]       <= shin[13:0];
        swmon_pkg::OP_ANALOG:   analog_sel_o      <= shin[4:0];
        default: ;
      endcase
    end
  end

  // reset flag: set by reset, cleared at cs rise
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) rst_flag <= 1'b1;
    else if (dev_rst) rst_flag <= 1'b1;
    else if (cs_rise) rst_flag <= 1'b0;
  end

  // interrupt: set on enabled change while awake; a change during cs low survives the clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_act   <= 1'b0;
      evt_in_cs <= 1'b0;
    end else begin
      if (sw_evt && !sleep) int_act <= 1'b1;
      else if (cs_rise && !evt_in_cs) int_act <= 1'b0;
      if (cs_fall) evt_in_cs <= 1'b0;                      // latch point
      else if (sw_evt && sel) evt_in_cs <= 1'b1;
    end
  end
  assign lnk.int_n_o  = 1'b0;
  assign lnk.int_n_oe = int_act;

  // mode: wake sources; without logic supply only wake pin, switch, timer
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) sleep <= 1'b0;
    else if (sleep) begin
      if (cs_fall) sleep <= 1'b0;
      else if (pw_s[1] && wk_s[1] && int_fall) sleep <= 1'b0;
      else if (wk_fall && (!pw_s[1] || int_s[1])) sleep <= 1'b0;
      else if (sw_evt || int_timer_i) sleep <= 1'b0;
    end else if (sleep_req_i && cs_s[1]) sleep <= 1'b1;
  end
  assign sleep_o       = sleep;
  assign lnk.wake_n_oe = ~sleep;
endmodule : swmon_dev

// ### rtl/swmon_host.sv
`timescale 1ns/10ps
// serial master: sclk idles low, cs_n only moves with sclk low
module swmon_host (
  input  wire logic        ref_clk_i, // 50 MHz
  input  wire logic        rstn_i,    // async active low
  input  wire logic [3:0]  addr_i,    // register address
  input  wire logic [23:0] wdata_i,   // write data
  input  wire logic        wr_i,      // write strobe
  input  wire logic        rd_i,      // read strobe
  output logic      [23:0] rdata_o,   // read data, cycle after rd_i
  swmon_if.host            lnk        // serial link
);
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_LAG} hstate_e;
  hstate_e     st;
  logic [7:0]  div;
  logic [5:0]  nbit;
  logic [47:0] tx;
  logic [47:0] rx;
  logic [23:0] tx_lo;
  logic [23:0] tx_hi;
  logic        chain;
  logic        wake_acc;
  logic [1:0]  sdo_s;
  logic [1:0]  int_s;
  logic [1:0]  wk_s;
  logic        div_end;
  logic [5:0]  nbits_total;

  assign div_end     = (div == 8'(swmon_pkg::LINK_DIV - 1));
  assign nbits_total = chain ? 6'(swmon_pkg::CHAIN_BITS) : 6'(swmon_pkg::WORD_BITS);

  // pin synchronisers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdo_s <= 2'h3;
      int_s <= 2'h3;
      wk_s  <= 2'h3;
    end else begin
      sdo_s <= {sdo_s[0], lnk.sdo_line};
      int_s <= {int_s[0], lnk.int_n};
      wk_s  <= {wk_s[0], lnk.wake_n};
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_lo <= 24'h000000;
      tx_hi <= 24'h000000;
      chain <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == swmon_pkg::HA_TXLO) tx_lo <= wdata_i;
      else if (addr_i == swmon_pkg::HA_TXHI) tx_hi <= wdata_i;
      else if (addr_i == swmon_pkg::HA_CTRL && st == H_IDLE) chain <= wdata_i[1];
    end
  end

  // transfer engine: sdi changes with rising sclk; the bit standing at the falling edge
  // reaches sdo_s only later, so it is taken at the end of the low half
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st       <= H_IDLE;
      div      <= 8'h00;
      nbit     <= 6'h00;
      tx       <= 48'h000000000000;
      rx       <= 48'h000000000000;
      wake_acc <= 1'b0;
      lnk.cs_n <= 1'b1;
      lnk.sclk <= 1'b0;
      lnk.sdi  <= 1'b0;
    end else begin
      div <= div_end ? 8'h00 : 8'(div + 8'h01);
      case (st)
        H_IDLE: begin
          if (wr_i && addr_i == swmon_pkg::HA_CTRL && wdata_i[0]) begin
            st       <= H_LEAD;
            div      <= 8'h00;
            nbit     <= 6'h00;
            wake_acc <= wk_s[1];      // device asleep: returned data may be stale
            tx       <= wdata_i[1] ? {tx_hi, tx_lo} : {tx_lo, 24'h000000};
            lnk.cs_n <= 1'b0;          // sclk already low
          end
        end
        H_LEAD: if (div_end) begin
          lnk.sdi <= tx[47];
          tx      <= {tx[46:0], 1'b0};
          st      <= H_HIGH;
          lnk.sclk <= 1'b1;
        end
        H_HIGH: if (div_end) begin
          lnk.sclk <= 1'b0;           // falling edge: device samples sdi
          nbit     <= 6'(nbit + 6'h01);
          st       <= (6'(nbit + 6'h01) == nbits_total) ? H_LAG : H_LOW;
        end
        H_LOW: if (div_end) begin
          rx       <= {rx[46:0], sdo_s[1]};
          lnk.sdi  <= tx[47];
          tx       <= {tx[46:0], 1'b0};
          lnk.sclk <= 1'b1;
          st       <= H_HIGH;
        end
        H_LAG: if (div_end) begin
          rx       <= {rx[46:0], sdo_s[1]}; // last bit
          lnk.cs_n <= 1'b1;           // sclk low
          st       <= H_IDLE;
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // register read port
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) rdata_o <= 24'h000000;
    else if (rd_i) begin
      if (addr_i == swmon_pkg::HA_RXLO) rdata_o <= rx[23:0];
      else if (addr_i == swmon_pkg::HA_RXHI) rdata_o <= rx[47:24];
      else if (addr_i == swmon_pkg::HA_TXLO) rdata_o <= tx_lo;
      else if (addr_i == swmon_pkg::HA_TXHI) rdata_o <= tx_hi;
      else if (addr_i == swmon_pkg::HA_STATUS)
        rdata_o <= {20'h00000, wake_acc, wk_s[1], int_s[1], st != H_IDLE};
      else rdata_o <= 24'h000000;
    end
  end
endmodule : swmon_host

// ### rtl/swmon_if.sv
`timescale 1ns/10ps
interface swmon_if;
  logic cs_n;       // chip select, host drives
  logic sclk;       // serial clock, host drives
  logic sdi;        // host to device data
  logic sdo;        // device data out
  logic sdo_oe;     // device drives sdo
  logic int_n_o;    // device pulls interrupt low (value 0)
  logic int_n_oe;   // device open-drain enable
  logic wake_n_oe;  // device pulls wake low
  logic wake_ext_oe;// external party pulls wake low
  logic int_ext_oe; // another device on the shared line pulls interrupt low
  logic int_n;      // resolved shared interrupt line
  logic wake_n;     // resolved wake line
  logic sdo_line;   // resolved sdo, pulled high when released
  assign int_n    = (int_n_oe | int_ext_oe) ? 1'b0 : 1'b1;
  assign wake_n   = (wake_n_oe | wake_ext_oe) ? 1'b0 : 1'b1;
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  modport dev  (input cs_n, sclk, sdi, int_n, wake_n, output sdo, sdo_oe, int_n_o, int_n_oe, wake_n_oe);
  modport host (output cs_n, sclk, sdi, input sdo_line, int_n, wake_n);
endinterface : swmon_if

// ### rtl/swmon_pkg.sv
package swmon_pkg;
  localparam int WORD_BITS      = 24;               // one command / status word
  localparam int CHAIN_BITS     = 48;               // two devices in series
  localparam int NUM_DP         = 8;                // dual_polarity_inputs
  localparam int NUM_GO         = 14;               // ground_only_inputs
  localparam int NUM_SW         = NUM_DP + NUM_GO;  // 22 switch bits
  localparam int RESET_FLAG_BIT = 22;               // status reset flag position
  localparam int THERM_FLAG_BIT = 23;               // status thermal flag position
  localparam int CMD_OP_MSB     = 23;               // command code field
  localparam int CMD_OP_LSB     = 16;
  localparam int WET_TIMER_MS   = 20;               // default wetting timer, ms
  localparam int CLK_PER_NS     = 20;               // ref_clk_i period
  localparam int LINK_DIV       = 4;                // ref clocks per sclk half period at the host
  localparam logic [4:0]  ANALOG_SEL_RST = 5'h00;   // no channel selected
  localparam logic [7:0]  OP_SETTINGS   = 8'h01;
  localparam logic [7:0]  OP_WAKE_DP    = 8'h02;
  localparam logic [7:0]  OP_WAKE_GO    = 8'h03;
  localparam logic [7:0]  OP_METAL_DP   = 8'h04;
  localparam logic [7:0]  OP_METAL_GO   = 8'h05;
  localparam logic [7:0]  OP_WTMR_DP    = 8'h07;
  localparam logic [7:0]  OP_WTMR_GO    = 8'h08;
  localparam logic [7:0]  OP_TRI_DP     = 8'h09;
  localparam logic [7:0]  OP_TRI_GO     = 8'h0A;
  localparam logic [7:0]  OP_ANALOG     = 8'h0B;
  localparam logic [7:0]  OP_RESET      = 8'h7F;
  // host register map
  localparam logic [3:0]  HA_CTRL   = 4'h0; // w: bit0 start, bit1 chained
  localparam logic [3:0]  HA_TXLO   = 4'h1; // 24 bits of the command word, sent second when chained
  localparam logic [3:0]  HA_TXHI   = 4'h2; // first word sent when chained
  localparam logic [3:0]  HA_RXLO   = 4'h3; // last received word
  localparam logic [3:0]  HA_RXHI   = 4'h4; // first received word when chained
  localparam logic [3:0]  HA_STATUS = 4'h5; // bit0 busy, bit1 irq_n, bit2 wake_n, bit3 wake_access
endpackage : swmon_pkg
